// >>> rtl/fbp_array.sv
// flash storage array: one read port, one write port, flip-flop storage
`timescale 1ns/10ps
module fbp_array (
   input  wire logic                        clk_sys_i,
   input  wire logic                        rst_n_i,
   input  wire logic [fbp_pkg::ADDR_W-1:0]  rd_addr_i,
   output logic      [fbp_pkg::DATA_W-1:0]  rd_data_o,
   input  wire logic                        wr_en_i,
   input  wire logic [fbp_pkg::ADDR_W-1:0]  wr_addr_i,
   input  wire logic [fbp_pkg::DATA_W-1:0]  wr_data_i
);
   logic [fbp_pkg::DATA_W-1:0] mem_r [fbp_pkg::WORDS];

   // combinational read so the owner can answer on the edge after the request
   assign rd_data_o = mem_r[rd_addr_i];

   // -----------------------------------------------------------------
   // storage, reset to the erased state
   // -----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < fbp_pkg::WORDS; gi++) begin : g_word
         always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               mem_r[gi] <= fbp_pkg::ERASED_WORD;
            end else if (wr_en_i && wr_addr_i == fbp_pkg::ADDR_W'(gi)) begin
               mem_r[gi] <= wr_data_i;
            end
         end
      end
   endgenerate
endmodule // fbp_array

// >>> rtl/fbp_pkg.sv
// package: geometry and command codes of the flash protection block
package fbp_pkg;
   // geometry: 8 KB of 32-bit words, 1 KB erase units, 2 KB regions
   localparam int unsigned WORDS       = 2048;
   localparam int unsigned ADDR_W      = 11;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned UNITS       = 8;
   localparam int unsigned UNIT_W      = 3;
   localparam int unsigned UNIT_WORDS  = 256;
   localparam int unsigned UNIT_LSB    = 8;
   localparam int unsigned REGIONS     = 4;
   localparam int unsigned REGION_LSB  = 9;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

   // per-region protection field: bit 0 read-only, bit 1 execute-only
   localparam int unsigned PROT_RO_BIT = 0;
   localparam int unsigned PROT_XO_BIT = 1;
   localparam logic [1:0]  PROT_RST    = 2'h0;

   // requester kinds on the read port
   typedef enum logic [1:0] {
      FBP_SRC_FETCH = 2'h0,
      FBP_SRC_DATA  = 2'h1,
      FBP_SRC_DBG   = 2'h2
   } fbp_src_t;

   // modify commands
   typedef enum logic [1:0] {
      FBP_CMD_NONE  = 2'h0,
      FBP_CMD_PROG  = 2'h1,
      FBP_CMD_ERASE = 2'h2
   } fbp_cmd_t;

   // erase sweep states, gray along idle -> sweep -> done
   typedef enum logic [1:0] {
      FBP_ST_IDLE  = 2'b00,
      FBP_ST_SWEEP = 2'b01,
      FBP_ST_DONE  = 2'b11
   } fbp_state_t;
endpackage

// >>> rtl/fbp_top.sv
// flash block erase and protection controller, top level
//
// Notes on behaviour
// [R1] The array holds eight kilobytes of storage.
// [R2] A read is answered on the clock edge after it is requested, no wait.
// [R3] Storage is split in 1 KB erase units, each erasable alone.
// [R4] Erasing a unit writes every bit of that unit to one.
// [R5] Pairs of erase units form 2 KB regions, each with own protection.
// [R6] Each region may be read-only, execute-only, or neither.
// [R7] Read-only regions refuse all erase and program commands.
// [R8] Execute-only regions refuse modify and only answer fetch reads. The code acks every read; other sources get deny and zero data.
// [R9] Execute-only regions hide contents from data and debugger reads.
// [R10] Unprotected regions allow all; a refused command changes nothing.
`timescale 1ns/10ps
module fbp_top (
   input  wire logic                          clk_sys_i,
   input  wire logic                          nrst_i,
   // read port
   input  wire logic                          rd_req_i,
   input  wire logic [1:0]                    rd_src_i,
   input  wire logic [fbp_pkg::ADDR_W-1:0]    rd_addr_i,
   output logic                               rd_ack_o,
   output logic                               rd_deny_o,
   output logic      [fbp_pkg::DATA_W-1:0]    rd_data_o,
   // modify port
   input  wire logic                          mod_req_i,
   input  wire logic [1:0]                    mod_cmd_i,
   input  wire logic [fbp_pkg::ADDR_W-1:0]    mod_addr_i,
   input  wire logic [fbp_pkg::DATA_W-1:0]    mod_data_i,
   output logic                               mod_busy_o,
   output logic                               mod_done_o,
   output logic                               mod_deny_o,
   // protection settings, two bits per region
   input  wire logic [2*fbp_pkg::REGIONS-1:0] prot_i
);
   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // -----------------------------------------------------------------
   // protection decode
   // -----------------------------------------------------------------
   function automatic logic [1:0] region_prot(
      input logic [2*fbp_pkg::REGIONS-1:0] p,
      input logic [fbp_pkg::ADDR_W-1:0]    a);
      logic [1:0] idx;
      idx = a[fbp_pkg::ADDR_W-1:fbp_pkg::REGION_LSB];
      region_prot = p[2*idx +: 2]; // [R5]
   endfunction

   wire [1:0] rd_prot  = region_prot(prot_i, rd_addr_i);
   wire [1:0] mod_prot = region_prot(prot_i, mod_addr_i);
   wire rd_xo  = rd_prot[fbp_pkg::PROT_XO_BIT];
   // either protection bit blocks modify [R6] [R7] [R8]
   wire mod_locked = mod_prot[fbp_pkg::PROT_RO_BIT] |
                     mod_prot[fbp_pkg::PROT_XO_BIT];
   wire rd_ok = !rd_xo ||
                (rd_src_i == fbp_pkg::FBP_SRC_FETCH); // [R8] [R9]

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   logic [fbp_pkg::DATA_W-1:0] arr_rd;
   logic                       wr_en;
   logic [fbp_pkg::ADDR_W-1:0] wr_addr;
   logic [fbp_pkg::DATA_W-1:0] wr_data;

   fbp_array u_array (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_r),
      .rd_addr_i (rd_addr_i),
      .rd_data_o (arr_rd),
      .wr_en_i   (wr_en),
      .wr_addr_i (wr_addr),
      .wr_data_i (wr_data)
   ); // [R1]

   // read answered on the edge after the request: one cycle, no wait [R2]
   always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rd_ack_o  <= 1'b0;
         rd_deny_o <= 1'b0;
         rd_data_o <= '0;
      end else begin
         rd_ack_o  <= rd_req_i;
         rd_deny_o <= rd_req_i && !rd_ok;
         // hidden words read as zero so nothing leaks [R9]
         if (rd_req_i) begin
            rd_data_o <= rd_ok ? arr_rd : '0;
         end
      end
   end

   // -----------------------------------------------------------------
   // modify path: program one word, or sweep one erase unit
   // -----------------------------------------------------------------
   fbp_pkg::fbp_state_t             st_r, st_nxt;
   logic [fbp_pkg::UNIT_W-1:0]      unit_r;
   logic [fbp_pkg::UNIT_LSB-1:0]    idx_r;

   wire idle     = (st_r == fbp_pkg::FBP_ST_IDLE);
   wire take     = idle && mod_req_i;
   wire is_prog  = (mod_cmd_i == fbp_pkg::FBP_CMD_PROG);
   wire is_erase = (mod_cmd_i == fbp_pkg::FBP_CMD_ERASE);
   wire allow    = take && !mod_locked && (is_prog || is_erase); // [R10]
   wire refuse   = take && !allow; // [R7] [R8]
   wire last     = (idx_r == 8'hFF);

   // old contents of the program target, so a program only clears bits
   logic [fbp_pkg::DATA_W-1:0] arr_prog_old;
   assign arr_prog_old = u_array.mem_r[mod_addr_i];

   // a program write lands at once; erase writes one word per cycle
   assign wr_en   = (allow && is_prog) || (st_r == fbp_pkg::FBP_ST_SWEEP);
   assign wr_addr = (st_r == fbp_pkg::FBP_ST_SWEEP) ?
                    {unit_r, idx_r} : mod_addr_i; // [R3]
   // flash programming only clears bits, it never sets them
   assign wr_data = (st_r == fbp_pkg::FBP_ST_SWEEP) ?
                    fbp_pkg::ERASED_WORD : (arr_prog_old & mod_data_i); // [R4]

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         fbp_pkg::FBP_ST_IDLE: begin
            if (allow && is_erase) begin
               st_nxt = fbp_pkg::FBP_ST_SWEEP;
            end
         end
         fbp_pkg::FBP_ST_SWEEP: begin
            if (last) begin
               st_nxt = fbp_pkg::FBP_ST_DONE;
            end
         end
         fbp_pkg::FBP_ST_DONE: st_nxt = fbp_pkg::FBP_ST_IDLE;
         default:              st_nxt = fbp_pkg::FBP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r       <= fbp_pkg::FBP_ST_IDLE;
         unit_r     <= '0;
         idx_r      <= '0;
         mod_done_o <= 1'b0;
         mod_deny_o <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         mod_deny_o <= refuse;
         mod_done_o <= (allow && is_prog) ||
                       (st_r == fbp_pkg::FBP_ST_SWEEP && last);
         if (take) begin
            unit_r <= mod_addr_i[fbp_pkg::ADDR_W-1:fbp_pkg::UNIT_LSB];
            idx_r  <= '0;
         end else if (st_r == fbp_pkg::FBP_ST_SWEEP) begin
            idx_r  <= idx_r + 8'h01;
         end
      end
   end

   assign mod_busy_o = !idle;
endmodule // fbp_top

// >>> sim/fbp_asserts.sv
// checker: port-level properties of the flash protection block
`timescale 1ns/10ps
module fbp_asserts (
   input wire logic        clk_sys_i,
   input wire logic        nrst_i,
   input wire logic        rd_req_i,
   input wire logic [1:0]  rd_src_i,
   input wire logic [10:0] rd_addr_i,
   input wire logic        rd_ack_o,
   input wire logic        rd_deny_o,
   input wire logic [31:0] rd_data_o,
   input wire logic        mod_req_i,
   input wire logic [1:0]  mod_cmd_i,
   input wire logic [10:0] mod_addr_i,
   input wire logic [31:0] mod_data_i,
   input wire logic        mod_busy_o,
   input wire logic        mod_done_o,
   input wire logic        mod_deny_o,
   input wire logic [7:0]  prot_i
);
   wire [1:0] rp   = prot_i[{rd_addr_i[10:9], 1'h0} +: 2];
   wire [1:0] mp   = prot_i[{mod_addr_i[10:9], 1'h0} +: 2];
   wire       take = mod_req_i && !mod_busy_o;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_sweep;
      mod_busy_o [*8];
   endsequence
   sequence s_end;
      mod_done_o && mod_busy_o ##1 !mod_busy_o;
   endsequence
   read_ack_a: assert property (rd_req_i |=> rd_ack_o)
      else $error("read not answered next cycle");
   open_read_a: assert property (rd_req_i && (rd_src_i == 2'h0 || !rp[1])
      |=> !rd_deny_o) else $error("allowed read denied");
   hide_data_a: assert property (rd_req_i && rd_src_i != 2'h0 && rp[1]
      |=> rd_deny_o && rd_data_o == 32'h0) else $error("word not hidden");
   deny_ack_a: assert property (rd_deny_o |-> rd_ack_o)
      else $error("deny without ack");
   lock_mod_a: assert property (take && mp != 2'h0
      |=> mod_deny_o && !mod_done_o) else $error("locked modify taken");
   bad_cmd_a: assert property (take && mp == 2'h0 && mod_cmd_i[0] ==
      mod_cmd_i[1] |=> mod_deny_o) else $error("bad command taken");
   prog_done_a: assert property (take && mp == 2'h0
      && mod_cmd_i == 2'h1 |=> mod_done_o && !mod_deny_o)
      else $error("program not done");
   erase_run_a: assert property (take && mp == 2'h0
      && mod_cmd_i == 2'h2 |=> s_sweep ##249 s_end)
      else $error("erase sweep length wrong");
endmodule // fbp_asserts

bind fbp_top fbp_asserts u_chk (
   .clk_sys_i  (clk_sys_i),
   .nrst_i     (nrst_i),
   .rd_req_i   (rd_req_i),
   .rd_src_i   (rd_src_i),
   .rd_addr_i  (rd_addr_i),
   .rd_ack_o   (rd_ack_o),
   .rd_deny_o  (rd_deny_o),
   .rd_data_o  (rd_data_o),
   .mod_req_i  (mod_req_i),
   .mod_cmd_i  (mod_cmd_i),
   .mod_addr_i (mod_addr_i),
   .mod_data_i (mod_data_i),
   .mod_busy_o (mod_busy_o),
   .mod_done_o (mod_done_o),
   .mod_deny_o (mod_deny_o),
   .prot_i     (prot_i)
);

// >>> sim/fbp_host.sv
// partner model: fetch, data bus and debugger read requester
`timescale 1ns/10ps
module fbp_host (
   input  wire logic        clk_sys_i,
   output logic             rd_req_i,
   output logic [1:0]       rd_src_i,
   output logic [10:0]      rd_addr_i,
   input  wire logic        rd_ack_o,
   input  wire logic        rd_deny_o,
   input  wire logic [31:0] rd_data_o
);
   initial begin
      rd_req_i = 1'h0;
      rd_src_i = 2'h0;
      rd_addr_i = 11'h000;
   end
   // released lines carry the inverse so stale values never match
   task automatic rd(input logic [1:0] s, input logic [10:0] a,
                     output logic [31:0] d, output logic dn, output logic ok);
      @(negedge clk_sys_i);
      rd_req_i = 1'h1;
      rd_src_i = s;
      rd_addr_i = a;
      @(negedge clk_sys_i);
      rd_req_i = 1'h0;
      rd_src_i = ~s;
      rd_addr_i = ~a;
      ok = rd_ack_o;
      d = rd_data_o;
      dn = rd_deny_o;
   endtask
endmodule // fbp_host

// >>> sim/testbench.sv
// testbench: directed scenarios for the flash protection block
`timescale 1ns/10ps
module testbench;
   logic        clk_sys_i, nrst_i, rd_req_i, mod_req_i, dn, ok;
   logic        rd_ack_o, rd_deny_o, mod_busy_o, mod_done_o, mod_deny_o;
   logic [1:0]  rd_src_i, mod_cmd_i;
   logic [10:0] rd_addr_i, mod_addr_i;
   logic [31:0] mod_data_i, rd_data_o, d;
   logic [7:0]  prot_i;
   int          fail_count, checks;
   fbp_top DUT (
      .clk_sys_i  (clk_sys_i),
      .nrst_i     (nrst_i),
      .rd_req_i   (rd_req_i),
      .rd_src_i   (rd_src_i),
      .rd_addr_i  (rd_addr_i),
      .rd_ack_o   (rd_ack_o),
      .rd_deny_o  (rd_deny_o),
      .rd_data_o  (rd_data_o),
      .mod_req_i  (mod_req_i),
      .mod_cmd_i  (mod_cmd_i),
      .mod_addr_i (mod_addr_i),
      .mod_data_i (mod_data_i),
      .mod_busy_o (mod_busy_o),
      .mod_done_o (mod_done_o),
      .mod_deny_o (mod_deny_o),
      .prot_i     (prot_i)
   );
   fbp_host host (
      .clk_sys_i (clk_sys_i),
      .rd_req_i  (rd_req_i),
      .rd_src_i  (rd_src_i),
      .rd_addr_i (rd_addr_i),
      .rd_ack_o  (rd_ack_o),
      .rd_deny_o (rd_deny_o),
      .rd_data_o (rd_data_o)
   );
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [1:0] s, input logic [10:0] a,
                      input logic [31:0] e, input logic edn);
      host.rd(s, a, d, dn, ok);
      chk({31'h0, ok}, 32'h1);
      chk(d, e);
      chk({31'h0, dn}, {31'h0, edn});
   endtask
   // waits for done or deny; a hang counts as a mismatch
   task automatic mod(input logic [1:0] c, input logic [10:0] a,
                      input logic [31:0] v, input logic edn);
      int n;
      @(negedge clk_sys_i);
      mod_req_i = 1'h1;
      mod_cmd_i = c;
      mod_addr_i = a;
      mod_data_i = v;
      @(negedge clk_sys_i);
      mod_req_i = 1'h0;
      mod_data_i = ~v;
      chk({31'h0, mod_busy_o}, {31'h0, c == 2'h2 && !edn});
      n = 0;
      while (mod_done_o !== 1'h1 && mod_deny_o !== 1'h1 && n < 300) begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 300) begin
         $display("BAD t=%0t wait %h limit %h", $time, n, 32'h0000_012C);
         fail_count++;
         conclude();
      end
      chk({31'h0, mod_deny_o}, {31'h0, edn});
      @(negedge clk_sys_i);
   endtask
   initial begin
      clk_sys_i = 1'h0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      {nrst_i, mod_req_i, mod_cmd_i, mod_addr_i, mod_data_i, prot_i} = '0;
      repeat (8) @(negedge clk_sys_i);
      nrst_i = 1'h1;
      repeat (3) @(negedge clk_sys_i);
      rdc(2'h0, 11'h7FF, 32'hFFFF_FFFF, 1'h0);
      mod(2'h1, 11'h005, 32'h1234_5678, 1'h0);
      mod(2'h1, 11'h105, 32'h0F0F_0F0F, 1'h0);
      mod(2'h3, 11'h005, 32'h0000_0000, 1'h1);
      mod(2'h0, 11'h005, 32'h0000_0000, 1'h1);
      rdc(2'h1, 11'h005, 32'h1234_5678, 1'h0);
      $display("open region test done");
      mod(2'h2, 11'h0A0, 32'h0000_0000, 1'h0);
      rdc(2'h1, 11'h005, 32'hFFFF_FFFF, 1'h0);
      rdc(2'h2, 11'h0FF, 32'hFFFF_FFFF, 1'h0);
      rdc(2'h2, 11'h105, 32'h0F0F_0F0F, 1'h0);
      $display("erase test done");
      mod(2'h1, 11'h205, 32'h00FF_00FF, 1'h0);
      prot_i = 8'h04;
      mod(2'h1, 11'h205, 32'h0000_0000, 1'h1);
      mod(2'h2, 11'h2FF, 32'h0000_0000, 1'h1);
      rdc(2'h1, 11'h205, 32'h00FF_00FF, 1'h0);
      mod(2'h1, 11'h105, 32'h0000_0000, 1'h0);
      rdc(2'h1, 11'h105, 32'h0000_0000, 1'h0);
      $display("read-only test done");
      mod(2'h1, 11'h405, 32'hA5A5_A5A5, 1'h0);
      prot_i = 8'h20;
      rdc(2'h0, 11'h405, 32'hA5A5_A5A5, 1'h0);
      rdc(2'h1, 11'h405, 32'h0000_0000, 1'h1);
      rdc(2'h2, 11'h405, 32'h0000_0000, 1'h1);
      rdc(2'h3, 11'h405, 32'h0000_0000, 1'h1);
      mod(2'h2, 11'h405, 32'h0000_0000, 1'h1);
      mod(2'h1, 11'h405, 32'h0000_0000, 1'h1);
      prot_i = 8'h00;
      rdc(2'h1, 11'h405, 32'hA5A5_A5A5, 1'h0);
      $display("execute-only test done");
      conclude();
   end
endmodule // testbench
